// ==== rtl/pgcs_regs.svh ====
/*
   Register offsets, field positions, reset values and timing counts for the power-ok and
   clock-source control bank. Assumes it is included once per compilation unit by bare name.
*/
// What this block does
// RULE1 - Tracking off: internal oscillator, PLL disabled
// RULE2 - Tracking on: PLL runs, external clock auto-used; the code does so only while active_or_standby is high
// RULE3 - Sync clock appearing or vanishing raises interrupt; the code flags it only while the PLL is enabled
// RULE4 - Frequency code n means n+1 MHz, 0x18+ reserved
// RULE5 - Software writes zero to clock control bit five
// RULE6 - Polarity bit sets power-ok active output level
// RULE7 - Drive type: push-pull or open-drain output
// RULE8 - Linear window bit adds overvoltage monitoring
// RULE9 - Converter window bit adds overvoltage monitoring
// RULE10 - Per-source enables include regulators in result
// RULE11 - Thermal gating forces inactive during warning
// RULE12 - Fault gating uses latched faults, not live
// RULE13 - Mode bit selects gated or continuous mode
// RULE14 - Selected regulator dropping power-ok latches fault
// RULE15 - Write-one clears fault only while output valid
// RULE16 - Power-ok active-to-inactive sets sticky interrupt flag
// RULE17 - Live power-ok needs all enabled sources good
`ifndef PGCS_REGS_SVH
`define PGCS_REGS_SVH

// Byte offsets of the registers on the 8-bit address bus.
`define PGCS_OFS_CLK_CTRL   8'h14
`define PGCS_OFS_CFG_A      8'h15
`define PGCS_OFS_CFG_B      8'h16
`define PGCS_OFS_FAULT      8'h17
`define PGCS_OFS_IRQ_STAT   8'h19
`define PGCS_OFS_IRQ_CLR    8'h1A
`define PGCS_OFS_IRQ_EN     8'h1B
`define PGCS_OFS_STATUS     8'h1C

// Clock control fields.
`define PGCS_CLK_TRACK_BIT  6
`define PGCS_CLK_RSVD_BIT   5
`define PGCS_FREQ_MSB       4
`define PGCS_FREQ_MAX       5'h17

// Reset values.
`define PGCS_RST_CLK_CTRL   8'h00
`define PGCS_RST_CFG_A      8'h0F
`define PGCS_RST_CFG_B      8'h00
`define PGCS_RST_FAULT      4'h0
`define PGCS_RST_IRQ        2'h0

// Interrupt bit positions.
`define PGCS_IRQ_PG_DROP    0
`define PGCS_IRQ_SYNC_CHG   1
`define PGCS_IRQ_MSB        1

// Configuration B fields; bits above the top one are reserved and read zero.
`define PGCS_CFGB_THERM_BIT 2
`define PGCS_CFGB_LATCH_BIT 1
`define PGCS_CFGB_MODE_BIT  0
`define PGCS_CFGB_MSB       2

// Sync clock presence timeout in microseconds and the system clock rate in MHz.
`define PGCS_SYNC_TIMEOUT_US 2
`define PGCS_CLK_MHZ         10

`endif

// ==== rtl/pgcs_pkg.sv ====
/*
   Types shared by the power-ok and clock-source control bank.
   Assumes pgcs_regs.svh supplies the numeric constants.
*/
package pgcs_pkg;

   // Power-ok configuration register A as its fields.
   typedef struct packed {
      logic       polarity;        // Active level select.
      logic       drive_type;      // 0 push-pull, 1 open-drain.
      logic       linear_window;   // Linear regulators: add overvoltage check.
      logic       converter_window;// Converters: add overvoltage check.
      logic [3:0] watch;           // {lin1, lin0, conv1, conv0}.
   } pgcs_cfg_a_t;

   // Per-regulator monitor inputs.
   typedef struct packed {
      logic [3:0] under_ok;        // Above undervoltage threshold.
      logic [3:0] over_ok;         // Below overvoltage threshold.
   } pgcs_mon_t;

   // Clock source state machine.
   typedef enum logic [1:0] {
      PGCS_CLK_RC   = 2'b00,
      PGCS_CLK_PLL  = 2'b01,
      PGCS_CLK_EXT  = 2'b10
   } pgcs_clk_state_t;

endpackage

// ==== rtl/pgcs_bank.sv ====
/*
   Power-ok generation, per-regulator fault latching, clock-source selection and the
   register bank, reached over Avalon-MM with waitrequest. Assumes monitor inputs and the
   sync clock input are synchronous to sys_clk and that the master holds a request until
   waitrequest is seen low.
*/
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "pgcs_regs.svh"

module pgcs_bank
   import pgcs_pkg::*;
#(
   parameter int SYNC_TIMEOUT_CYC = `PGCS_SYNC_TIMEOUT_US * `PGCS_CLK_MHZ
)
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // Avalon-MM slave.
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [7:0]  avs_writedata,
   output logic [7:0]       avs_readdata,
   output logic             avs_waitrequest,
   // Regulator monitors, thermal warning, sync clock input and active_or_standby.
   input  wire pgcs_mon_t   mon,
   input  wire logic        thermal_warning,
   input  wire logic        sync_clock_input,
   input  wire logic        active_or_standby,
   // Power-ok pin as three signals.
   output logic             power_ok_output,
   output logic             power_ok_oe,
   output logic             power_ok_operating_mode,
   // Clock selection outputs and the interrupt.
   output logic             pll_enable,
   output logic             use_ext_clock,
   output logic [4:0]       ext_clock_freq_code,
   output logic             irq
);

   logic [7:0]      clk_ctrl_q;    // Clock source control register.
   pgcs_cfg_a_t     cfg_a_q;       // Power-ok configuration A.
   logic [7:0]      cfg_b_q;       // Power-ok configuration B.
   logic [3:0]      fault_q;       // Latched per-source fault flags.
   logic [1:0]      irq_stat_q;    // Sticky interrupt status.
   logic [1:0]      irq_en_q;      // Interrupt enables.
   logic            ack_q;         // One-cycle answer pulse.
   logic            pg_active_q;   // Registered logical power-ok.
   logic            pg_active_d;   // Next logical power-ok.
   logic [3:0]      src_ok;        // Each regulator currently valid.
   logic [3:0]      src_bad;       // Enabled and invalid.
   logic            live_ok;       // Live result.
   logic            wr_hit;        // Write accepted this cycle.
   logic            sync_prev_q;   // Last sample of the sync input.
   logic [15:0]     sync_cnt_q;    // Cycles since last sync edge.
   logic            sync_present_q;// External clock seen recently.
   logic            sync_present_d;
   pgcs_clk_state_t clk_state_q;   // Clock source state.

   // Answer one cycle after a request is raised; waitrequest is combinational so reads
   // and writes complete on the second edge.
   // Every access costs exactly one wait cycle. A faster zero-wait answer would need the
   // read mux on the readdata path, which the house rule keeps registered; one cycle of
   // latency is cheap on a configuration bus that is touched only a few times a second.
   // The master must hold address, direction and write data through the wait cycle,
   // because the write is applied only at the edge where waitrequest is seen low.
   // After a completed access ack_q falls again, so a back-to-back request simply waits
   // its own cycle and can never be acknowledged by the tail of the previous one.
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_hit          = avs_write & ack_q;

   // Acknowledge pulse, cleared after each completed access.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // Read data is registered at the acknowledge edge; unmapped offsets read zero.
   // The mux is loaded on the first cycle of a read, so the value is already standing
   // when waitrequest falls and stays put until the next read is taken.
   // The clear register is write-only and so falls into the zero default on a read.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         avs_readdata <= 8'h00;
      end
      else if (avs_read & ~ack_q)
      begin
         unique case (avs_address)
            `PGCS_OFS_CLK_CTRL: avs_readdata <= clk_ctrl_q;
            `PGCS_OFS_CFG_A:    avs_readdata <= cfg_a_q;
            `PGCS_OFS_CFG_B:    avs_readdata <= cfg_b_q;
            `PGCS_OFS_FAULT:    avs_readdata <= {4'h0, fault_q};
            `PGCS_OFS_IRQ_STAT: avs_readdata <= {6'h00, irq_stat_q};
            `PGCS_OFS_IRQ_EN:   avs_readdata <= {6'h00, irq_en_q};
            `PGCS_OFS_STATUS:   avs_readdata <= {4'h0, src_ok};
            default:            avs_readdata <= 8'h00;
         endcase
      end
   end

   // Configuration registers. Bit 5 of clock control is forced to zero since
   // software must leave it clear; a reserved frequency code is refused and the old kept.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         clk_ctrl_q <= `PGCS_RST_CLK_CTRL;
         cfg_a_q    <= `PGCS_RST_CFG_A;
         cfg_b_q    <= `PGCS_RST_CFG_B;
         irq_en_q   <= `PGCS_RST_IRQ;
      end
      else if (wr_hit)
      begin
         if (avs_address == `PGCS_OFS_CLK_CTRL)
         begin
            clk_ctrl_q[`PGCS_CLK_TRACK_BIT] <= avs_writedata[`PGCS_CLK_TRACK_BIT];
            clk_ctrl_q[`PGCS_CLK_RSVD_BIT]  <= 1'b0; // RULE5
            if (avs_writedata[`PGCS_FREQ_MSB:0] <= `PGCS_FREQ_MAX) // RULE4
            begin
               clk_ctrl_q[`PGCS_FREQ_MSB:0] <= avs_writedata[`PGCS_FREQ_MSB:0];
            end
         end
         if (avs_address == `PGCS_OFS_CFG_A)
         begin
            cfg_a_q <= avs_writedata;
         end
         // Reserved bits of configuration B are kept at zero whatever is written.
         if (avs_address == `PGCS_OFS_CFG_B)
         begin
            cfg_b_q <= {5'h00, avs_writedata[`PGCS_CFGB_MSB:0]};
         end
         // Only the two implemented interrupt enables are stored.
         if (avs_address == `PGCS_OFS_IRQ_EN)
         begin
            irq_en_q <= avs_writedata[`PGCS_IRQ_MSB:0];
         end
      end
   end

   assign ext_clock_freq_code = clk_ctrl_q[`PGCS_FREQ_MSB:0]; // RULE4

   // A source is valid when above its undervoltage threshold and, with the window
   // bit for its kind set, also below its overvoltage threshold.
   always_comb
   begin
      src_ok[3:2] = mon.under_ok[3:2] & (mon.over_ok[3:2] | {2{~cfg_a_q.linear_window}}); // RULE8
      src_ok[1:0] = mon.under_ok[1:0] & (mon.over_ok[1:0] | {2{~cfg_a_q.converter_window}}); // RULE9
      src_bad     = cfg_a_q.watch & ~src_ok; // RULE10
      live_ok     = (src_bad == 4'h0) & ~(cfg_b_q[`PGCS_CFGB_THERM_BIT] & thermal_warning); // RULE11 RULE17
      pg_active_d = cfg_b_q[`PGCS_CFGB_LATCH_BIT] ?
                    ((fault_q == 4'h0) & ~(cfg_b_q[`PGCS_CFGB_THERM_BIT] & thermal_warning)) :
                    live_ok; // RULE12
   end

   // In latched mode power-ok follows the fault flags and not the live monitors, so a
   // short dip that has already recovered keeps the output inactive until software has
   // seen it and cleared the flag. Thermal gating still applies in both modes, since a
   // hot die is a live condition that software cannot acknowledge away.

   // Logical power-ok, registered so the pin comes from a flip-flop.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pg_active_q <= 1'b0;
      end
      else
      begin
         pg_active_q <= pg_active_d;
      end
   end

   // Pin level and enable. Open-drain only drives the low level.
   always_comb
   begin
      power_ok_output = pg_active_q ^ cfg_a_q.polarity; // RULE6
      power_ok_oe     = ~cfg_a_q.drive_type | ~power_ok_output; // RULE7
   end

   // The mode bit is only exported; the gating that it selects lives outside this block.
   assign power_ok_operating_mode = cfg_b_q[`PGCS_CFGB_MODE_BIT]; // RULE13

   // Fault flags: an enabled, invalid source latches; write-one clears only while the
   // source is valid, and a new fault in the same cycle wins.
   // Flags latch from the live monitors in either power-ok mode. A source that stays bad
   // re-sets its flag every cycle, so software cannot hide a standing fault by clearing;
   // the price is that a clear written during a fault is silently lost and must be
   // repeated once the rail has recovered.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         fault_q <= `PGCS_RST_FAULT;
      end
      else
      begin
         fault_q <= src_bad | // RULE14
                    (fault_q & ~((wr_hit && avs_address == `PGCS_OFS_FAULT) ?
                                 (avs_writedata[3:0] & src_ok) : 4'h0)); // RULE15
      end
   end

   // Sync clock presence: an edge restarts the timeout; silence past it means gone.
   // The input is sampled by sys_clk, so only sync clocks well below half the system
   // rate are seen edge by edge; a faster clock aliases and may look intermittent.
   // The counter saturates at the timeout so a long silence never wraps back to present.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         sync_prev_q    <= 1'b0;
         sync_cnt_q     <= 16'h0000;
         sync_present_q <= 1'b0;
      end
      else
      begin
         sync_prev_q    <= sync_clock_input;
         sync_present_q <= sync_present_d;
         if (sync_clock_input != sync_prev_q)
         begin
            sync_cnt_q <= 16'h0000;
         end
         else if (sync_cnt_q != 16'(SYNC_TIMEOUT_CYC))
         begin
            sync_cnt_q <= sync_cnt_q + 16'h0001;
         end
      end
   end

   assign sync_present_d = (sync_clock_input != sync_prev_q) |
                           (sync_present_q & (sync_cnt_q != 16'(SYNC_TIMEOUT_CYC)));

   // Clock source selection: RC when tracking is off or active_or_standby is low; with tracking on, PLL in standby and active,
   // switching to the external clock whenever it is present.
   // The state follows the presence flag one cycle late, which keeps the switch glitch
   // free: the selection never changes in the same cycle as the flag it is based on.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         clk_state_q <= PGCS_CLK_RC;
      end
      else if (!clk_ctrl_q[`PGCS_CLK_TRACK_BIT] || !active_or_standby)
      begin
         clk_state_q <= PGCS_CLK_RC; // RULE1
      end
      else
      begin
         clk_state_q <= sync_present_q ? PGCS_CLK_EXT : PGCS_CLK_PLL; // RULE2
      end
   end

   assign pll_enable    = (clk_state_q != PGCS_CLK_RC);
   assign use_ext_clock = (clk_state_q == PGCS_CLK_EXT);

   // Sticky interrupt status; hardware set wins over a clear in the same cycle.
   // Losing a clear is harmless, since software sees the bit again, while losing a set
   // would hide an event for good. Sync changes only count while the PLL is enabled.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         irq_stat_q <= `PGCS_RST_IRQ;
      end
      else
      begin
         irq_stat_q[`PGCS_IRQ_PG_DROP] <= (pg_active_q & ~pg_active_d) | // RULE16
            (irq_stat_q[`PGCS_IRQ_PG_DROP] &
             ~(wr_hit && avs_address == `PGCS_OFS_IRQ_CLR && avs_writedata[`PGCS_IRQ_PG_DROP]));
         irq_stat_q[`PGCS_IRQ_SYNC_CHG] <= (pll_enable & (sync_present_q ^ sync_present_d)) | // RULE3
            (irq_stat_q[`PGCS_IRQ_SYNC_CHG] &
             ~(wr_hit && avs_address == `PGCS_OFS_IRQ_CLR && avs_writedata[`PGCS_IRQ_SYNC_CHG]));
      end
   end

   assign irq = |(irq_stat_q & irq_en_q);

   // Checks on the main relations.
   AST_POL: assert property (@(posedge sys_clk) disable iff (srst)
      1'b1 |-> power_ok_output == (pg_active_q ^ cfg_a_q.polarity)) else $error("polarity wrong"); // RULE6
   AST_OD: assert property (@(posedge sys_clk) disable iff (srst)
      (cfg_a_q.drive_type && power_ok_output) |-> !power_ok_oe) else $error("open drain drove high"); // RULE7
   AST_RC: assert property (@(posedge sys_clk) disable iff (srst)
      !clk_ctrl_q[`PGCS_CLK_TRACK_BIT] |=> !pll_enable) else $error("pll on while off"); // RULE1
   AST_EXT: assert property (@(posedge sys_clk) disable iff (srst)
      (clk_ctrl_q[`PGCS_CLK_TRACK_BIT] && active_or_standby && sync_present_q) |=> use_ext_clock)
      else $error("external clock not used"); // RULE2
   AST_FAULT: assert property (@(posedge sys_clk) disable iff (srst)
      (src_bad != 4'h0) |=> ((fault_q & $past(src_bad)) == $past(src_bad))) else $error("fault lost"); // RULE14
   AST_LATCHGATE: assert property (@(posedge sys_clk) disable iff (srst)
      (cfg_b_q[1] && fault_q != 4'h0) |=> !pg_active_q) else $error("fault gating ignored"); // RULE12
   AST_THERM: assert property (@(posedge sys_clk) disable iff (srst)
      (cfg_b_q[2] && thermal_warning) |=> !pg_active_q) else $error("thermal gating ignored"); // RULE11
   AST_DROP: assert property (@(posedge sys_clk) disable iff (srst)
      $fell(pg_active_q) |-> irq_stat_q[`PGCS_IRQ_PG_DROP]) else $error("drop flag missing"); // RULE16
   AST_RSVD: assert property (@(posedge sys_clk) disable iff (srst)
      1'b1 |-> !clk_ctrl_q[`PGCS_CLK_RSVD_BIT] && clk_ctrl_q[`PGCS_FREQ_MSB:0] <= `PGCS_FREQ_MAX)
      else $error("reserved clock bits"); // RULE4

   // Tracking on in standby or active must run the PLL from the next cycle.
   AST_PLL_ON: assert property (@(posedge sys_clk) disable iff (srst)
      (clk_ctrl_q[`PGCS_CLK_TRACK_BIT] && active_or_standby) |=> pll_enable)
      else $error("pll not enabled"); // RULE2

   // A change of sync presence while the PLL runs must leave the sticky bit set.
   AST_SYNC_IRQ: assert property (@(posedge sys_clk) disable iff (srst)
      (pll_enable && (sync_present_q != sync_present_d)) |=> irq_stat_q[`PGCS_IRQ_SYNC_CHG])
      else $error("sync change flag missing"); // RULE3

   // Live mode: any enabled invalid source forces power-ok inactive next cycle.
   AST_LIVE: assert property (@(posedge sys_clk) disable iff (srst)
      (!cfg_b_q[`PGCS_CFGB_LATCH_BIT] && src_bad != 4'h0) |=> !pg_active_q)
      else $error("live power ok with bad source"); // RULE17

   // A clear written to the fault flags must not clear a flag whose source is invalid.
   AST_CLR_GUARD: assert property (@(posedge sys_clk) disable iff (srst)
      (wr_hit && avs_address == `PGCS_OFS_FAULT) |=>
      ((fault_q & $past(fault_q & ~src_ok)) == $past(fault_q & ~src_ok)))
      else $error("fault cleared while invalid"); // RULE15

   // A request that has not yet been acknowledged must be held off.
   AST_WAIT: assert property (@(posedge sys_clk) disable iff (srst)
      ((avs_read || avs_write) && !ack_q) |-> avs_waitrequest)
      else $error("request answered early");

   COV_DROP: cover property (@(posedge sys_clk) disable iff (srst) $fell(pg_active_q));
   COV_SYNC_GONE: cover property (@(posedge sys_clk) disable iff (srst) $fell(sync_present_q));
   COV_EXT: cover property (@(posedge sys_clk) disable iff (srst) $rose(use_ext_clock));
   COV_CLR: cover property (@(posedge sys_clk) disable iff (srst) $fell(fault_q[0]));

endmodule

// ==== testbench/tb.sv ====
/*
   Self-checking bench for the power-ok and clock-source control bank.
   Assumes pgcs_pkg and pgcs_bank are compiled first and pgcs_regs.svh is on the include path.
*/
`timescale 1ns/1ps
`include "pgcs_regs.svh"

module tb;
   import pgcs_pkg::*;

   logic       sys_clk, srst, avs_read, avs_write, avs_waitrequest;  // Clock, reset and bus handshake.
   logic [7:0] avs_address, avs_writedata, avs_readdata;              // Bus address and data.
   pgcs_mon_t  mon;                                                   // Regulator monitor levels.
   logic       thermal_warning, sync_clock_input, active_or_standby;  // Status inputs.
   logic       power_ok_output, power_ok_oe, power_ok_operating_mode; // Power-ok pin outputs.
   logic       pll_enable, use_ext_clock, irq;                        // Clock and interrupt outputs.
   logic [4:0] ext_clock_freq_code;                                   // Frequency code output.
   int         fails, n_compared, cyc;                                // Counters.

   pgcs_bank #(.SYNC_TIMEOUT_CYC(20)) dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .mon(mon), .thermal_warning(thermal_warning),
      .sync_clock_input(sync_clock_input), .active_or_standby(active_or_standby),
      .power_ok_output(power_ok_output), .power_ok_oe(power_ok_oe),
      .power_ok_operating_mode(power_ok_operating_mode), .pll_enable(pll_enable),
      .use_ext_clock(use_ext_clock), .ext_clock_freq_code(ext_clock_freq_code), .irq(irq));

   // Free-running 100 ns clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // Cuts a hang short; the whole sequence needs well under two thousand cycles.
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fails++;
         end_sim();
      end
   end

   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Compares with case equality so an unknown never matches.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One bus cycle: holds the request until waitrequest is low at a rising edge.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge sys_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q & m, exp);
   endtask

   // Lets the registered power-ok path settle, then checks the pin pair.
   task automatic pin(input logic o, input logic oe);
      repeat (4) @(posedge sys_clk);
      chk({6'h00, power_ok_output, power_ok_oe}, {6'h00, o, oe});
   endtask

   // Reset values and an unmapped read.
   task automatic t_reset();
      rd(`PGCS_OFS_CFG_A, 8'hFF, 8'h0F);
      rd(`PGCS_OFS_CFG_B, 8'hFF, 8'h00);
      rd(`PGCS_OFS_FAULT, 8'hFF, 8'h00);
      rd(`PGCS_OFS_CLK_CTRL, 8'hFF, 8'h00);
      rd(8'h30, 8'hFF, 8'h00);
      pin(1'b1, 1'b1);
   endtask

   // Clock tracking, sync interrupts both ways, masking and the top valid frequency code.
   task automatic t_clock();
      wr(`PGCS_OFS_IRQ_CLR, 8'h03);
      wr(`PGCS_OFS_IRQ_EN, 8'h02);
      wr(`PGCS_OFS_CLK_CTRL, 8'h45);
      repeat (2) @(posedge sys_clk);
      chk({7'h00, pll_enable}, 8'h01);
      repeat (20) @(posedge sys_clk) sync_clock_input <= ~sync_clock_input;
      chk({6'h00, use_ext_clock, irq}, 8'h03);
      rd(`PGCS_OFS_IRQ_STAT, 8'h02, 8'h02);
      wr(`PGCS_OFS_IRQ_CLR, 8'h02);
      repeat (10) @(posedge sys_clk) sync_clock_input <= ~sync_clock_input;
      chk({7'h00, irq}, 8'h00);
      repeat (30) @(posedge sys_clk);
      chk({6'h00, use_ext_clock, irq}, 8'h01);
      active_or_standby <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk({7'h00, pll_enable}, 8'h00);
      active_or_standby <= 1'b1;
      wr(`PGCS_OFS_IRQ_EN, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h00);
      wr(`PGCS_OFS_IRQ_CLR, 8'h03);
      wr(`PGCS_OFS_CLK_CTRL, 8'h05);
      rd(`PGCS_OFS_CLK_CTRL, 8'hFF, 8'h05);
      chk({7'h00, pll_enable}, 8'h00);
      wr(`PGCS_OFS_CLK_CTRL, 8'h17);
      rd(`PGCS_OFS_CLK_CTRL, 8'hFF, 8'h17);
      chk({3'h0, ext_clock_freq_code}, 8'h17);
   endtask

   // Window monitoring and per-source selection for both regulator kinds.
   task automatic t_window();
      mon <= '{under_ok: 4'b1101, over_ok: 4'b1010};
      wr(`PGCS_OFS_CFG_A, 8'h24);
      pin(1'b0, 1'b1);
      wr(`PGCS_OFS_CFG_A, 8'h04);
      pin(1'b1, 1'b1);
      wr(`PGCS_OFS_CFG_A, 8'h11);
      pin(1'b0, 1'b1);
      wr(`PGCS_OFS_CFG_A, 8'h01);
      pin(1'b1, 1'b1);
      mon <= '{under_ok: 4'hF, over_ok: 4'hF};
      wr(`PGCS_OFS_FAULT, 8'h0F);
   endtask

   // Polarity, drive type, thermal gating and the mode output.
   task automatic t_pin();
      wr(`PGCS_OFS_CFG_A, 8'hCF);
      pin(1'b0, 1'b1);
      thermal_warning <= 1'b1;
      pin(1'b0, 1'b1);
      wr(`PGCS_OFS_CFG_A, 8'h4F);
      pin(1'b1, 1'b0);
      wr(`PGCS_OFS_CFG_A, 8'h0F);
      wr(`PGCS_OFS_CFG_B, 8'h04);
      pin(1'b0, 1'b1);
      thermal_warning <= 1'b0;
      wr(`PGCS_OFS_CFG_B, 8'h01);
      pin(1'b1, 1'b1);
      chk({7'h00, power_ok_operating_mode}, 8'h01);
      wr(`PGCS_OFS_CFG_B, 8'h00);
      wr(`PGCS_OFS_FAULT, 8'h0F);
   endtask

   // Fault latching, guarded clear, fault gating and the drop interrupt.
   task automatic t_fault();
      wr(`PGCS_OFS_IRQ_CLR, 8'h03);
      wr(`PGCS_OFS_IRQ_EN, 8'h01);
      mon <= '{under_ok: 4'b0111, over_ok: 4'hF};
      pin(1'b0, 1'b1);
      rd(`PGCS_OFS_FAULT, 8'hFF, 8'h08);
      rd(`PGCS_OFS_IRQ_STAT, 8'h01, 8'h01);
      chk({7'h00, irq}, 8'h01);
      wr(`PGCS_OFS_CFG_A, 8'h07);
      wr(`PGCS_OFS_FAULT, 8'h08);
      rd(`PGCS_OFS_FAULT, 8'hFF, 8'h08);
      wr(`PGCS_OFS_CFG_A, 8'h0F);
      mon <= '{under_ok: 4'hF, over_ok: 4'hF};
      wr(`PGCS_OFS_CFG_B, 8'h02);
      pin(1'b0, 1'b1);
      wr(`PGCS_OFS_FAULT, 8'h08);
      rd(`PGCS_OFS_FAULT, 8'hFF, 8'h00);
      pin(1'b1, 1'b1);
      wr(`PGCS_OFS_IRQ_CLR, 8'h01);
      rd(`PGCS_OFS_IRQ_STAT, 8'h01, 8'h00);
      chk({7'h00, irq}, 8'h00);
   endtask

   // Main sequence: every input is defined at time zero, then a four-cycle reset.
   initial
   begin
      srst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      mon = '{under_ok: 4'hF, over_ok: 4'hF};
      {thermal_warning, sync_clock_input} = 2'b00;
      active_or_standby = 1'b1;
      {fails, n_compared, cyc} = '0;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      t_reset();
      t_clock();
      t_window();
      t_pin();
      t_fault();
      end_sim();
   end
endmodule
